/* core/mcx_consts.vh */
`ifndef MCX_CONSTS_VH
`define MCX_CONSTS_VH
// apb register byte offsets
`define MCX_A_INSTR   12'h000
`define MCX_A_OPERAND 12'h004
`define MCX_A_OPLO    12'h008
`define MCX_A_CTRL    12'h00C
`define MCX_A_STATE   12'h010
`define MCX_A_IND     12'h014
`define MCX_A_CHECK   12'h018
`define MCX_A_RESLO   12'h01C
`define MCX_A_RESHI   12'h020
`define MCX_A_GPR     12'h040
`define MCX_A_FPR     12'h080
// control register fields
`define MCX_C_GO      0
`define MCX_C_PROB    1
`define MCX_C_FLOAT   2
`define MCX_C_INVAD   3
`define MCX_C_PROT    4
`define MCX_C_MISAL   5
// parameter byte bits
`define MCX_P_SPROT   12
`define MCX_P_EQUATE  13
`define MCX_P_XLATE   14
`define MCX_P_SUMMARY 15
// opcode fields (bits 0..4 op, bit 0 is msb)
`define MCX_OP_MASK   5'b0110_0
`define MCX_FN_EN     3'b010
`define MCX_FN_DIS    3'b011
`define MCX_OP_DIV    5'b1110_1
`define MCX_FN_DW     4'b0110
`define MCX_OP_FST    5'b0010_0
`define MCX_OP_FRR    5'b0010_0
`define MCX_FN_FADD   4'b0000
// indicator bits
`define MCX_I_EVEN    0
`define MCX_I_CARRY   1
`define MCX_I_OVFL    2
`define MCX_I_NEG     3
`define MCX_I_ZERO    4
// check code values
`define MCX_K_NONE    3'h0
`define MCX_K_PRIV    3'h1
`define MCX_K_INVAD   3'h2
`define MCX_K_PROT    3'h3
`define MCX_K_SPEC    3'h4
`define MCX_K_INVFN   3'h5
`define MCX_K_FPEXC   3'h6
`endif

/* core/mcx_divider.v */
`timescale 1ns/1ps
module mcx_divider (
  // operands
  input  wire [15:0] dividend,
  input  wire [15:0] divisor,
  // results
  output wire [15:0] quotient,
  output wire [15:0] remainder,
  output wire        div_zero,
  output wire        div_ovfl
);
  wire [15:0] a_mag = dividend[15] ? (16'h0000 - dividend) : dividend;
  wire [15:0] b_mag = divisor[15] ? (16'h0000 - divisor) : divisor;
  wire [15:0] q_mag = (b_mag == 16'h0000) ? 16'h0000 : a_mag / b_mag;
  wire [15:0] r_mag = (b_mag == 16'h0000) ? 16'h0000 : a_mag % b_mag;
  wire        q_neg = dividend[15] ^ divisor[15];
  assign div_zero  = (divisor == 16'h0000);
  // only -32768 / -1 leaves the word range
  assign div_ovfl  = div_zero | (!q_neg & q_mag[15]);
  assign quotient  = q_neg ? (16'h0000 - q_mag) : q_mag;
  assign remainder = dividend[15] ? (16'h0000 - r_mag) : r_mag;
endmodule

/* core/mcx_exec.v */
`timescale 1ns/1ps
`include "mcx_consts.vh"
// What this block does
// [RULE1] enable sets masks per parameter one-bits
// [RULE2] disable clears masks per parameter one-bits
// [RULE3] software keeps parameter bits 8-11 zero
// [RULE4] software spaces summary enable from disable
// [RULE5] disable bit 14 turns translator off
// [RULE6] enable bit 12 stops translator, ignores 14
// [RULE7] enable 14 without 12 starts translator
// [RULE8] mask instructions keep indicators unchanged
// [RULE9] mask instruction in problem state: privilege check
// [RULE10] divide word: quotient r, remainder r+1
// [RULE11] divide clears carry, overflow; both on zero
// [RULE12] quotient overflow sets overflow; else flags follow
// [RULE13] storage out of range: invalid address check
// [RULE14] problem state foreign storage: protect check
// [RULE15] single storage add into high half
// [RULE16] register add into second register
// [RULE17] double add uses full 64 bits
// [RULE18] zero fraction gives plus sign, zero exponent
// [RULE19] add sets overflow, even, clears carry
// [RULE20] misaligned storage address: specification check
// [RULE21] no float option: invalid function trap
// [RULE22] float error traps but still completes
// [RULE23] disable decoded by op and function bits
// [RULE24] register form uses two-bit register fields
module mcx_exec (
  // clock and reset
  input  wire        mclk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // processor state outputs
  output wire        storage_protect,
  output wire        equate_spaces,
  output wire        translator_on,
  output wire        summary_mask,
  output wire        check_valid,
  output wire [2:0]  check_code
);
  reg [15:0] instr_q;
  reg [31:0] operand_q;
  reg [31:0] oplo_q;
  reg [5:0]  ctrl_q;
  reg [3:0]  state_q;
  reg [4:0]  ind_q;
  reg [2:0]  check_q;
  reg [31:0] reslo_q;
  reg [31:0] reshi_q;
  reg [15:0] gpr_q [0:7];
  reg [63:0] fpr_q [0:3];

  assign storage_protect = state_q[0];
  assign equate_spaces   = state_q[1];
  assign translator_on   = state_q[2];
  assign summary_mask    = state_q[3];
  assign check_valid     = (check_q != `MCX_K_NONE);
  assign check_code      = check_q;
  assign pready          = 1'b1;

  wire wr_en = psel & penable & pwrite;
  wire go    = wr_en & (paddr == `MCX_A_CTRL) & pwdata[`MCX_C_GO];

  // instruction fields, bit 0 is the msb of instr_q
  wire [4:0] op_f  = instr_q[15:11];
  wire [2:0] r_f   = instr_q[10:8];
  wire [1:0] first_float_reg_field  = instr_q[9:8];   // [RULE24]
  wire [1:0] second_float_reg_field = instr_q[7:6];   // [RULE24]
  wire [7:0] parm  = instr_q[7:0];
  wire       fstor = (op_f == `MCX_OP_FST) & ~instr_q[10];
  wire       freg  = (op_f == `MCX_OP_FRR) & instr_q[10];

  function [7:0] fdecode;
    input [15:0] w;
    begin
      fdecode = {w[15:11] == `MCX_OP_MASK, w[10:8] == `MCX_FN_EN,
                 w[10:8] == `MCX_FN_DIS, w[15:11] == `MCX_OP_DIV,
                 w[3:0] == `MCX_FN_DW, w[15:11] == `MCX_OP_FST,
                 w[3:1] == 3'b000, w[0]};
    end
  endfunction

  wire [7:0] dc = fdecode(instr_q);
  wire is_en   = dc[7] & dc[6];
  wire mask_disable_op = dc[7] & dc[5];                       // [RULE23]
  wire word_divide_op  = dc[4] & dc[3];
  wire fadd    = dc[2] & dc[1];
  wire float_add_single_op = fadd & ~dc[0];
  wire float_add_double_op = fadd & dc[0];

  // divide
  wire [2:0]  r_next = r_f + 3'd1;                            // [RULE10]
  wire [15:0] quo;
  wire [15:0] rem;
  wire        dzero;
  wire        dovf;
  mcx_divider u_div (
    .dividend  (gpr_q[r_f]),
    .divisor   (operand_q[15:0]),
    .quotient  (quo),
    .remainder (rem),
    .div_zero  (dzero),
    .div_ovfl  (dovf)
  );

  // float add operands
  wire [1:0]  fdst  = freg ? second_float_reg_field : r_f[1:0];
  wire [63:0] fsrc  = freg ? fpr_q[first_float_reg_field] :
                      {operand_q, oplo_q};
  wire [63:0] fsum;
  wire        fovf;
  wire        funf;
  mcx_fadd u_fadd (
    .op_a (fsrc),
    .op_b (fpr_q[fdst]),
    .dbl  (float_add_double_op),
    .sum  (fsum),
    .ovfl (fovf),
    .unfl (funf)
  );

  // check priority for the issued instruction
  // control bits written together with go apply to that go
  wire [5:0] ctl_w = {pwdata[5:1], 1'b0};
  reg [2:0] chk_d;
  always @* begin
    chk_d = `MCX_K_NONE;
    if (ctl_w[`MCX_C_INVAD] & ~freg & ~(dc[7])) begin
      chk_d = `MCX_K_INVAD;                                   // [RULE13]
    end else if (ctl_w[`MCX_C_PROB] & ctl_w[`MCX_C_PROT]) begin
      chk_d = `MCX_K_PROT;                                    // [RULE14]
    end else if (dc[7] & ctl_w[`MCX_C_PROB] & (is_en | mask_disable_op)) begin
      chk_d = `MCX_K_PRIV;                                    // [RULE9]
    end else if (fadd & ~ctl_w[`MCX_C_FLOAT]) begin
      chk_d = `MCX_K_INVFN;                                   // [RULE21]
    end else if (fadd & fstor & ctl_w[`MCX_C_MISAL]) begin
      chk_d = `MCX_K_SPEC;                                    // [RULE20]
    end else if (fadd & (fovf | funf)) begin
      chk_d = `MCX_K_FPEXC;                                   // [RULE22]
    end
  end

  // float indicators
  wire [4:0] find = {fsum == 64'h0, fsum[63], fovf | funf,    // [RULE19]
                     1'b0, funf};
  wire [15:0] dres = quo;
  wire [4:0] dind = dovf ? {3'b001, dzero, ind_q[0]} & 5'b00110 |
                    {ind_q[4:3], 3'b000} :
                    {dres == 16'h0, dres[15], 2'b00, ~dres[0]};  // [RULE11]

  integer k;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      instr_q   <= 16'h0000;
      operand_q <= 32'h0000_0000;
      oplo_q    <= 32'h0000_0000;
      ctrl_q    <= 6'h00;
      state_q   <= 4'h0;
      ind_q     <= 5'h00;
      check_q   <= `MCX_K_NONE;
      reslo_q   <= 32'h0000_0000;
      reshi_q   <= 32'h0000_0000;
      for (k = 0; k < 8; k = k + 1) begin
        gpr_q[k] <= 16'h0000;
      end
      for (k = 0; k < 4; k = k + 1) begin
        fpr_q[k] <= 64'h0000_0000_0000_0000;
      end
    end else if (go) begin
      check_q <= chk_d;
      ctrl_q  <= ctl_w;
      // instruction bit n sits at instr_q[15-n]
      if (is_en & (chk_d == `MCX_K_NONE)) begin
        if (parm[15 - `MCX_P_SPROT]) begin
          state_q[0] <= 1'b1;                                 // [RULE1]
          state_q[2] <= 1'b0;                                 // [RULE6]
        end else if (parm[15 - `MCX_P_XLATE]) begin
          state_q[2] <= 1'b1;                                 // [RULE7]
          state_q[0] <= 1'b0;                                 // [RULE7]
        end
        if (parm[15 - `MCX_P_EQUATE]) begin
          state_q[1] <= 1'b1;                                 // [RULE1]
        end
        if (parm[15 - `MCX_P_SUMMARY]) begin
          state_q[3] <= 1'b1;                                 // [RULE1]
        end
      end else if (mask_disable_op & (chk_d == `MCX_K_NONE)) begin
        if (parm[15 - `MCX_P_SPROT]) begin
          state_q[0] <= 1'b0;                                 // [RULE2]
        end
        if (parm[15 - `MCX_P_EQUATE]) begin
          state_q[1] <= 1'b0;                                 // [RULE2]
        end
        if (parm[15 - `MCX_P_XLATE]) begin
          state_q[2] <= 1'b0;                                 // [RULE5]
        end
        if (parm[15 - `MCX_P_SUMMARY]) begin
          state_q[3] <= 1'b0;                                 // [RULE2]
        end
      end else if (word_divide_op & (chk_d == `MCX_K_NONE)) begin
        ind_q <= dind;                                        // [RULE12]
        reslo_q <= {rem, quo};
        if (!dovf) begin
          gpr_q[r_f]    <= quo;                               // [RULE10]
          gpr_q[r_next] <= rem;                               // [RULE10]
        end
      end else if (fadd & ((chk_d == `MCX_K_NONE) |
                           (chk_d == `MCX_K_FPEXC))) begin
        ind_q <= find;                                        // [RULE19]
        reshi_q <= fsum[63:32];
        reslo_q <= fsum[31:0];
        if (float_add_double_op) begin
          fpr_q[fdst] <= fsum;                                // [RULE17]
        end else begin
          fpr_q[fdst] <= {fsum[63:32], fpr_q[fdst][31:0]};    // [RULE15] [RULE16]
        end
      end
      // mask ops and checked instructions, except float exception checks, keep indicators [RULE8]
    end else if (wr_en) begin
      case (paddr)
        `MCX_A_INSTR: begin
          instr_q <= pwdata[15:0];
        end
        `MCX_A_OPERAND: begin
          operand_q <= pwdata;
        end
        `MCX_A_OPLO: begin
          oplo_q <= pwdata;
        end
        `MCX_A_CTRL: begin
          ctrl_q <= {pwdata[5:1], 1'b0};
        end
        `MCX_A_IND: begin
          ind_q <= pwdata[4:0];
        end
        `MCX_A_CHECK: begin
          check_q <= `MCX_K_NONE;
        end
        default: begin
          if ((paddr[11:5] == 7'h02) & (paddr[1:0] == 2'b00)) begin
            gpr_q[paddr[4:2]] <= pwdata[15:0];
          end else if ((paddr[11:5] == 7'h04) &
                       (paddr[1:0] == 2'b00)) begin
            if (paddr[2]) begin
              fpr_q[paddr[4:3]][31:0] <= pwdata;
            end else begin
              fpr_q[paddr[4:3]][63:32] <= pwdata;
            end
          end
        end
      endcase
    end
  end

  // read mux
  wire mapped = (paddr[1:0] == 2'b00) & ((paddr <= `MCX_A_RESHI) |
                (paddr[11:5] == 7'h02) | (paddr[11:5] == 7'h04));
  assign pslverr = psel & penable & ~mapped;
  always @* begin
    case (paddr)
      `MCX_A_INSTR:   prdata = {16'h0000, instr_q};
      `MCX_A_OPERAND: prdata = operand_q;
      `MCX_A_OPLO:    prdata = oplo_q;
      `MCX_A_CTRL:    prdata = {26'h0, ctrl_q};
      `MCX_A_STATE:   prdata = {28'h0, state_q};
      `MCX_A_IND:     prdata = {27'h0, ind_q};
      `MCX_A_CHECK:   prdata = {29'h0, check_q};
      `MCX_A_RESLO:   prdata = reslo_q;
      `MCX_A_RESHI:   prdata = reshi_q;
      default: begin
        if (paddr[11:5] == 7'h02) begin
          prdata = {16'h0000, gpr_q[paddr[4:2]]};
        end else if (paddr[11:5] == 7'h04) begin
          prdata = paddr[2] ? fpr_q[paddr[4:3]][31:0] :
                   fpr_q[paddr[4:3]][63:32];
        end else begin
          prdata = 32'h0000_0000;
        end
      end
    endcase
  end
endmodule

/* core/mcx_fadd.v */
`timescale 1ns/1ps
// hex float: sign, 7-bit excess-64 characteristic, 56-bit fraction
module mcx_fadd (
  // operands, single precision uses the upper 32 bits
  input  wire [63:0] op_a,
  input  wire [63:0] op_b,
  input  wire        dbl,
  // result
  output reg  [63:0] sum,
  output reg         ovfl,
  output reg         unfl
);
  reg [6:0]  ca;
  reg [6:0]  cb;
  reg [59:0] fa;
  reg [59:0] fb;
  reg [59:0] fs;
  reg [7:0]  ch;
  reg        sa;
  reg        sb;
  reg        ss;
  reg [6:0]  diff;
  integer    i;
  always @* begin
    sa = op_a[63];
    sb = op_b[63];
    ca = op_a[62:56];
    cb = op_b[62:56];
    fa = {4'h0, op_a[55:32], (dbl ? op_a[31:0] : 32'h0000_0000)};
    fb = {4'h0, op_b[55:32], (dbl ? op_b[31:0] : 32'h0000_0000)};
    if (ca < cb) begin
      diff = cb - ca;
      fa = (diff > 7'd14) ? 60'h0 : (fa >> {diff, 2'b00});
      ch = {1'b0, cb};
    end else begin
      diff = ca - cb;
      fb = (diff > 7'd14) ? 60'h0 : (fb >> {diff, 2'b00});
      ch = {1'b0, ca};
    end
    if (sa == sb) begin
      fs = fa + fb;
      ss = sa;
    end else if (fa >= fb) begin
      fs = fa - fb;
      ss = sa;
    end else begin
      fs = fb - fa;
      ss = sb;
    end
    ovfl = 1'b0;
    unfl = 1'b0;
    if (fs[59:56] != 4'h0) begin
      fs = fs >> 4;
      ch = ch + 8'd1;
    end
    for (i = 0; i < 14; i = i + 1) begin
      if (fs != 60'h0 && fs[55:52] == 4'h0) begin
        fs = fs << 4;
        ch = ch - 8'd1;
      end
    end
    if (fs == 60'h0) begin
      sum = 64'h0000_0000_0000_0000; // [RULE18]
    end else begin
      if (ch[7] && ch != 8'h80) begin
        unfl = 1'b1;
      end
      if (ch == 8'h80) begin
        ovfl = 1'b1;
      end
      sum = {ss, ch[6:0], fs[55:0]};
      if (!dbl) begin
        sum[31:0] = 32'h0000_0000;
      end
    end
  end
endmodule

/* sim/mcx_exec_properties.sv */
`timescale 1ns/1ps
`include "mcx_consts.vh"
module mcx_exec_props (
  // clock and reset
  input wire        mclk,
  input wire        reset,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // processor state
  input wire        storage_protect,
  input wire        equate_spaces,
  input wire        translator_on,
  input wire        summary_mask,
  input wire        check_valid,
  input wire [2:0]  check_code
);
  logic [15:0] ins_q;
  logic        go;
  logic        ok;
  logic        en;
  logic        dis;
  logic        div;
  assign go  = psel && penable && pwrite && pwdata[0] &&
               paddr == `MCX_A_CTRL;
  assign ok  = go && !pwdata[1] && pwdata[5:3] == 3'h0;
  assign en  = ins_q[15:8] == 8'h62;
  assign dis = ins_q[15:8] == 8'h63;
  assign div = ins_q[15:11] == `MCX_OP_DIV;
  // copy of the instruction word last written
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      ins_q <= 16'h0000;
    else if (psel && penable && pwrite && paddr == `MCX_A_INSTR)
      ins_q <= pwdata[15:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_en_masks: assert property (
    ok && en && ins_q[2] && ins_q[0] |=> equate_spaces && summary_mask)
    else $error("enable masks");
  a_dis_masks: assert property (
    ok && dis && ins_q[0] |=> !summary_mask && !(ins_q[2] && equate_spaces))
    else $error("disable masks");
  a_dis_xlate: assert property (
    ok && dis && ins_q[1] |=> !translator_on)
    else $error("disable translator");
  a_en_protect: assert property (
    ok && en && ins_q[3] |=> storage_protect && !translator_on)
    else $error("enable protect");
  a_en_xlate: assert property (
    ok && en && ins_q[1] && !ins_q[3] |=> translator_on && !storage_protect)
    else $error("enable translator");
  a_priv_check: assert property (
    go && pwdata[1] && !pwdata[4] && (en || dis) |=> check_valid &&
    check_code == `MCX_K_PRIV && $stable(storage_protect))
    else $error("privilege check");
  a_invad_check: assert property (
    go && div && pwdata[3] && !pwdata[1] |=> check_code == `MCX_K_INVAD)
    else $error("invalid address");
  a_prot_check: assert property (
    go && div && pwdata[4] && pwdata[1] && !pwdata[3]
    |=> check_code == `MCX_K_PROT)
    else $error("protect check");
  a_float_off: assert property (
    go && !pwdata[2] && pwdata[5:3] == 3'h0 && !pwdata[1] &&
    ins_q[15:10] == 6'b0010_01 && ins_q[3:1] == 3'h0
    |=> check_code == `MCX_K_INVFN)
    else $error("float missing");
endmodule

/* sim/mcx_prog_model.sv */
`timescale 1ns/1ps
// program store: instruction words in execution order
module mcx_prog_model (
  // program counter
  input  wire  [3:0]  pc,
  // instruction word
  output logic [15:0] iword
);
  always_comb begin
    case (pc)
      4'h0: iword = 16'h620F; // bits 8-11 kept zero
      4'h1: iword = 16'h6202; // spacer after summary enable
      4'h2: iword = 16'h620A;
      4'h3: iword = 16'h6202;
      4'h4: iword = 16'h6302;
      4'h5: iword = 16'h6305;
      4'h6: iword = 16'h620F;
      4'h7: iword = 16'hE806;
      4'h8: iword = 16'hE806;
      4'h9: iword = 16'h2000;
      default: iword = 16'h2580;
    endcase
  end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "mcx_consts.vh"
module tb_top;
  logic        mclk, reset, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  logic [3:0]  pc;
  wire         pready, pslverr, sp, eq, xl, sm, cv;
  wire  [31:0] prdata;
  wire  [2:0]  cc;
  wire  [15:0] iw;
  int          num_errors, n_checks, i;
  // ctrl, expected state, expected check code
  logic [12:0] rows [11] = '{
    {6'h01, 4'hB, 3'h0}, {6'h01, 4'hE, 3'h0}, {6'h01, 4'hB, 3'h0},
    {6'h01, 4'hE, 3'h0}, {6'h01, 4'hA, 3'h0}, {6'h01, 4'h0, 3'h0},
    {6'h03, 4'h0, 3'h1}, {6'h09, 4'h0, 3'h2}, {6'h13, 4'h0, 3'h3},
    {6'h25, 4'h0, 3'h4}, {6'h01, 4'h0, 3'h5}};

  mcx_exec u_dut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .storage_protect(sp), .equate_spaces(eq), .translator_on(xl),
    .summary_mask(sm), .check_valid(cv), .check_code(cc));
  mcx_prog_model u_prog (.pc(pc), .iword(iw));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task run(input logic [15:0] w, input logic [5:0] c);
    apb(1'b1, `MCX_A_INSTR, {16'h0000, w});
    apb(1'b1, `MCX_A_CTRL, {26'h0, c});
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    close_out;
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pc = 4'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rdchk(`MCX_A_STATE, 32'h0);
    apb(1'b1, `MCX_A_IND, 32'h15);
    for (i = 0; i < 11; i++) begin
      pc <= i[3:0];
      @(posedge mclk);
      run(iw, rows[i][12:7]);
      apb(1'b0, `MCX_A_STATE, 32'h0);
      chk(r[3:0], rows[i][6:3]);
      chk({sm, xl, eq, sp}, rows[i][6:3]);
      chk(cv, rows[i][2:0] != 3'h0);
      if (rows[i][2:0] != 3'h0)
        chk(cc, rows[i][2:0]);
      apb(1'b1, `MCX_A_CHECK, 32'h0);
    end
    rdchk(`MCX_A_IND, 32'h15);
    done("masks");
    apb(1'b1, `MCX_A_IND, 32'h1F);
    apb(1'b1, 12'h05C, 32'h64);
    apb(1'b1, `MCX_A_OPERAND, 32'h7);
    run(16'hEF06, 6'h01);
    apb(1'b0, 12'h05C, 32'h0);
    chk(r[15:0], 16'h000E);
    apb(1'b0, `MCX_A_GPR, 32'h0);
    chk(r[15:0], 16'h0002);
    apb(1'b0, `MCX_A_IND, 32'h0);
    chk(r[4:1], 4'h0);
    apb(1'b1, `MCX_A_OPERAND, 32'h0);
    run(16'hEF06, 6'h01);
    apb(1'b0, `MCX_A_IND, 32'h0);
    chk(r[2:1], 2'b11);
    apb(1'b1, 12'h05C, 32'h8000);
    apb(1'b1, `MCX_A_OPERAND, 32'hFFFF);
    run(16'hEF06, 6'h01);
    apb(1'b0, `MCX_A_IND, 32'h0);
    chk(r[2:1], 2'b10);
    done("divide");
    apb(1'b1, `MCX_A_FPR, 32'h4110_0000);
    apb(1'b1, 12'h084, 32'h1234_5678);
    apb(1'b1, `MCX_A_OPERAND, 32'h4110_0000);
    apb(1'b1, `MCX_A_IND, 32'h1F);
    run(16'h2000, 6'h05);
    rdchk(`MCX_A_FPR, 32'h4120_0000);
    rdchk(12'h084, 32'h1234_5678);
    rdchk(`MCX_A_IND, 32'h0);
    apb(1'b1, 12'h088, 32'h4110_0000);
    apb(1'b1, 12'h090, 32'hC110_0000);
    apb(1'b1, 12'h094, 32'h0BAD_0BAD);
    run(16'h2580, 6'h05);
    rdchk(12'h090, 32'h0);
    rdchk(12'h094, 32'h0BAD_0BAD);
    rdchk(12'h088, 32'h4110_0000);
    rdchk(`MCX_A_IND, 32'h10);
    apb(1'b1, 12'h098, 32'h4110_0000);
    apb(1'b1, 12'h09C, 32'h1);
    apb(1'b1, `MCX_A_OPLO, 32'h0);
    run(16'h2301, 6'h05);
    rdchk(12'h098, 32'h4120_0000);
    rdchk(12'h09C, 32'h1);
    apb(1'b1, 12'h088, 32'h7F10_0000);
    apb(1'b1, `MCX_A_OPERAND, 32'h7FF0_0000);
    run(16'h2100, 6'h05);
    rdchk(`MCX_A_CHECK, 32'h6);
    rdchk(`MCX_A_IND, 32'h4);
    rdchk(12'h088, 32'h0010_0000);
    done("float");
    rdchk(12'h024, 32'h0);
    chk(e, 1'b1);
    done("apb");
    run(16'h620F, 6'h01);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rdchk(`MCX_A_STATE, 32'h0);
    chk({sp, eq, xl, sm}, 4'h0);
    done("reset");
    close_out;
  end
endmodule

bind mcx_exec mcx_exec_props u_props (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .storage_protect(storage_protect),
  .equate_spaces(equate_spaces), .translator_on(translator_on),
  .summary_mask(summary_mask), .check_valid(check_valid),
  .check_code(check_code));
